// ===== arfw_result_window.sv
// Top: SFR slave, result registers, window detector of the 12-bit converter back end
// What this block does
// - Right-justified: low result byte holds the lower eight result bits.
// - Left-justified: low byte bits 7:4 hold lowest four bits; 3:0 read zero.
// - Right-justified: high byte 3:0 top bits, 7:4 sign copy if differential.
// - Left-justified: high byte holds the eight most significant bits.
// - Single-ended results are unsigned, full scale 0x0FFF or 0xFFF0.
// - Differential results are two's complement, from 0xF800/0x8000 to 0x07FF/0x7FF0.
// - Every finished result is compared to limits in hardware, setting window flag.
// - Window flag is readable by polling as well as an interrupt request.
// - Each limit is a 16-bit word in separately writable high and low bytes.
// - Flag fires inside or outside the range depending on limit ordering.
// - Low result byte sits at address 0xBE on page 0.
// - Less-than limit high byte sits at 0xC7 page 0, reset zero.
// - Greater-than limit low byte is a read/write low half of that word.
// - A conversion lasts at least sixteen SAR clocks before results update.
`timescale 1ns/100ps
`default_nettype none
module arfw_result_window (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrPage,
  input wire logic sfrWrite,
  input wire logic sfrRead,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  input wire logic [11:0] coreCode,
  output logic convStart,
  output logic convActive,
  output logic convDoneIrq,
  output logic windowIrq
);
  // ****************************************
  // Reset release
  // ****************************************
  logic rstMeta_r;
  logic rstN_r;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_r <= 1'b0;
      rstN_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstN_r <= rstMeta_r;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] config_r;
  logic [7:0] control_r;
  logic [7:0] gtHigh_r;
  logic [7:0] gtLow_r;
  logic [7:0] ltHigh_r;
  logic [7:0] ltLow_r;
  logic [7:0] resHigh_r;
  logic [7:0] resLow_r;
  logic [3:0] pairCfg_r;
  logic [3:0] chanSel_r;
  logic [11:0] code_r;
  logic codeValid_r;

  // ****************************************
  // Decode
  // ****************************************
  logic pageHit;
  logic wrConfig;
  logic wrControl;
  logic wrGtHigh;
  logic wrGtLow;
  logic wrLtHigh;
  logic wrLtLow;
  logic wrResHigh;
  logic wrResLow;
  logic wrPair;
  logic wrChan;
  assign pageHit = sfrPage == arfw_pkg::PAGE_ZERO;
  assign wrConfig = sfrWrite && pageHit && sfrAddr == arfw_pkg::ADDR_CONFIG;
  assign wrControl = sfrWrite && pageHit && sfrAddr == arfw_pkg::ADDR_CONTROL;
  assign wrGtHigh = sfrWrite && pageHit && sfrAddr == arfw_pkg::ADDR_GT_HIGH;
  assign wrGtLow = sfrWrite && pageHit && sfrAddr == arfw_pkg::ADDR_GT_LOW;
  assign wrLtHigh = sfrWrite && pageHit && sfrAddr == arfw_pkg::ADDR_LT_HIGH;
  assign wrLtLow = sfrWrite && pageHit && sfrAddr == arfw_pkg::ADDR_LT_LOW;
  assign wrResHigh = sfrWrite && pageHit && sfrAddr == arfw_pkg::ADDR_RESULT_HIGH;
  assign wrResLow = sfrWrite && pageHit && sfrAddr == arfw_pkg::ADDR_RESULT_LOW;
  assign wrPair = sfrWrite && pageHit && sfrAddr == arfw_pkg::ADDR_PAIR_CONFIG;
  assign wrChan = sfrWrite && pageHit && sfrAddr == arfw_pkg::ADDR_CHANNEL_SEL;

  // ****************************************
  // Conversion timing
  // ****************************************
  logic enabled;
  logic leftAlign;
  logic busyWrite;
  logic sarBusy;
  logic sarDone;
  assign enabled = control_r[arfw_pkg::CTL_ENABLE_BIT];
  assign leftAlign = control_r[arfw_pkg::CTL_LEFT_BIT];
  // Only software starts are handled here; timer and pin triggers live elsewhere
  assign busyWrite = wrControl && sfrWdata[arfw_pkg::CTL_BUSY_BIT] && enabled;
  assign convStart = busyWrite && !sarBusy;

  // Slowest divider still runs the SAR clock above its ceiling at this system clock;
  // picking a legal divider is left to software
  arfw_sar_timer u_timer (
    .refClk(ref_clk),
    .rstN(rstN_r),
    .divider(config_r[arfw_pkg::CFG_DIV_LSB +: arfw_pkg::CFG_DIV_WIDTH]),
    .start(busyWrite),
    .busy(sarBusy),
    .done(sarDone)
  );

  // Which channel pair is differential follows the selected input
  logic differential;
  assign differential = (chanSel_r[3:1] == 3'h0) ? pairCfg_r[0] :
                        (chanSel_r[3:1] == 3'h1) ? pairCfg_r[1] :
                        (chanSel_r[3:1] == 3'h2) ? pairCfg_r[3] : 1'b0;

  // ****************************************
  // Formatting and window compare
  // ****************************************
  logic [7:0] fmtHigh;
  logic [7:0] fmtLow;
  logic windowHit;
  arfw_formatter u_fmt (
    .code(code_r),
    .leftAlign(leftAlign),
    .differential(differential),
    .gtLimit({gtHigh_r, gtLow_r}),
    .ltLimit({ltHigh_r, ltLow_r}),
    .highByte(fmtHigh),
    .lowByte(fmtLow),
    .hit(windowHit)
  );

  // Capture the core code as conversion ends; compare one cycle later
  always_ff @(posedge ref_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      code_r <= 12'h000;
      codeValid_r <= 1'b0;
    end else begin
      codeValid_r <= sarDone;
      if (sarDone) code_r <= coreCode;
    end
  end

  // Result bytes follow the format bit, also when it changes after capture
  always_ff @(posedge ref_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      resHigh_r <= arfw_pkg::RST_RESULT;
      resLow_r <= arfw_pkg::RST_RESULT;
    end else begin
      resHigh_r <= wrResHigh ? sfrWdata : fmtHigh;
      resLow_r <= wrResLow ? sfrWdata : fmtLow;
    end
  end

  // ****************************************
  // Control and limit registers
  // ****************************************
  logic setDone;
  logic setWindow;
  assign setDone = codeValid_r;
  assign setWindow = codeValid_r && windowHit;

  always_ff @(posedge ref_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      control_r <= arfw_pkg::RST_CONTROL;
    end else begin
      if (wrControl) control_r <= sfrWdata;
      control_r[arfw_pkg::CTL_BUSY_BIT] <= 1'b0;
      // Hardware set wins over a software clear in the same cycle
      if (setDone) control_r[arfw_pkg::CTL_DONE_BIT] <= 1'b1;
      if (setWindow) control_r[arfw_pkg::CTL_WINDOW_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      config_r <= arfw_pkg::RST_CONFIG;
      gtHigh_r <= arfw_pkg::RST_LIMIT;
      gtLow_r <= arfw_pkg::RST_LIMIT;
      ltHigh_r <= arfw_pkg::RST_LIMIT;
      ltLow_r <= arfw_pkg::RST_LIMIT;
      pairCfg_r <= arfw_pkg::RST_PAIR[3:0];
      chanSel_r <= arfw_pkg::RST_CHANNEL[3:0];
    end else begin
      if (wrConfig) config_r <= sfrWdata;
      if (wrGtHigh) gtHigh_r <= sfrWdata;
      if (wrGtLow) gtLow_r <= sfrWdata;
      if (wrLtHigh) ltHigh_r <= sfrWdata;
      if (wrLtLow) ltLow_r <= sfrWdata;
      if (wrPair) pairCfg_r <= sfrWdata[3:0] & arfw_pkg::PAIR_MASK;
      if (wrChan) chanSel_r <= sfrWdata[3:0];
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  logic [7:0] controlView;
  assign controlView = {control_r[7:5], sarBusy, control_r[3:0]};

  always_comb begin
    sfrRdata = 8'h00;
    if (sfrRead && pageHit) begin
      case (sfrAddr)
        arfw_pkg::ADDR_CONFIG: sfrRdata = config_r;
        arfw_pkg::ADDR_CONTROL: sfrRdata = controlView;
        arfw_pkg::ADDR_RESULT_HIGH: sfrRdata = resHigh_r;
        arfw_pkg::ADDR_RESULT_LOW: sfrRdata = resLow_r;
        arfw_pkg::ADDR_GT_HIGH: sfrRdata = gtHigh_r;
        arfw_pkg::ADDR_GT_LOW: sfrRdata = gtLow_r;
        arfw_pkg::ADDR_LT_HIGH: sfrRdata = ltHigh_r;
        arfw_pkg::ADDR_LT_LOW: sfrRdata = ltLow_r;
        arfw_pkg::ADDR_PAIR_CONFIG: sfrRdata = {4'h0, pairCfg_r};
        arfw_pkg::ADDR_CHANNEL_SEL: sfrRdata = {4'h0, chanSel_r};
        default: sfrRdata = 8'h00;
      endcase
    end
  end

  assign convActive = sarBusy;
  assign convDoneIrq = control_r[arfw_pkg::CTL_DONE_BIT];
  assign windowIrq = control_r[arfw_pkg::CTL_WINDOW_BIT];

  // ****************************************
  // Checks
  // ****************************************
  sequence s_result_lands;
    codeValid_r ##1 1'b1;
  endsequence
  sequence s_done_flag;
    codeValid_r ##1 convDoneIrq;
  endsequence

  a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    windowIrq && !(wrControl && !sfrWdata[arfw_pkg::CTL_WINDOW_BIT]) |=> windowIrq)
    else $error("window flag dropped without software clear");
  a_flag_on_hit: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    codeValid_r && windowHit |-> s_result_lands ##0 windowIrq)
    else $error("window hit did not set flag");
  a_flag_cause: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    $rose(windowIrq) |-> $past(setWindow) || $past(wrControl))
    else $error("window flag set without cause");
  a_low_right: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    !$past(leftAlign) && !$past(wrResLow) |-> resLow_r == $past(code_r[7:0]))
    else $error("right justified low byte wrong");
  a_low_left: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    $past(leftAlign) && !$past(wrResLow) |-> resLow_r[3:0] == 4'h0
      && resLow_r[7:4] == $past(code_r[3:0]))
    else $error("left justified low byte wrong");
  a_high_right: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    !$past(leftAlign) && !$past(wrResHigh) |-> resHigh_r[7:4] ==
      ($past(differential) ? {4{resHigh_r[3]}} : 4'h0))
    else $error("right justified high byte fill wrong");
  a_high_left: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    $past(leftAlign) && !$past(wrResHigh) |-> resHigh_r == $past(code_r[11:4]))
    else $error("left justified high byte wrong");
  a_lt_high_reg: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    wrLtHigh |=> ltHigh_r == $past(sfrWdata))
    else $error("less-than high byte not written");
  a_gt_low_reg: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    wrGtLow |=> gtLow_r == $past(sfrWdata) && gtHigh_r == $past(gtHigh_r))
    else $error("greater-than low byte write disturbed word");

  // ****************************************
  // Register map and flag checks
  // ****************************************
  // Limit bytes must not disturb their partner half
  a_gt_high_reg: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    wrGtHigh |=> gtHigh_r == $past(sfrWdata) && gtLow_r == $past(gtLow_r))
    else $error("greater-than high byte write disturbed word");
  a_lt_low_reg: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    wrLtLow |=> ltLow_r == $past(sfrWdata) && ltHigh_r == $past(ltHigh_r))
    else $error("less-than low byte write disturbed word");
  a_page_refused: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    sfrWrite && !pageHit |=> ltHigh_r == $past(ltHigh_r))
    else $error("write on another page reached a limit byte");
  a_low_addr_map: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    sfrRead && pageHit && sfrAddr == arfw_pkg::ADDR_RESULT_LOW |-> sfrRdata == resLow_r)
    else $error("low result byte not at its address");
  a_flag_poll: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    sfrRead && pageHit && sfrAddr == arfw_pkg::ADDR_CONTROL |->
      sfrRdata[arfw_pkg::CTL_WINDOW_BIT] == windowIrq)
    else $error("window flag not visible to polling");
  a_no_false_hit: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    !windowIrq && !setWindow && !wrControl |=> !windowIrq)
    else $error("window flag set without a hit");
  // Completion path: done pulse, capture, then the sticky flag
  a_done_sets: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    sarDone |=> s_done_flag)
    else $error("completion flag not set after conversion");
  a_start_busy: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    convStart |=> convActive)
    else $error("accepted start did not raise busy");
endmodule // arfw_result_window
`default_nettype wire

// ===== arfw_pkg.sv
// Package: register map, field positions, reset values and timing for the result formatter
package arfw_pkg;
  // ****************************************
  // Special function register addresses
  // ****************************************
  localparam logic [7:0] ADDR_CONFIG = 8'hBC;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'hBE;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'hBF;
  localparam logic [7:0] ADDR_GT_LOW = 8'hC4;
  localparam logic [7:0] ADDR_GT_HIGH = 8'hC5;
  localparam logic [7:0] ADDR_LT_LOW = 8'hC6;
  localparam logic [7:0] ADDR_LT_HIGH = 8'hC7;
  localparam logic [7:0] ADDR_CONTROL = 8'hE8;
  localparam logic [7:0] ADDR_PAIR_CONFIG = 8'hBA;
  localparam logic [7:0] ADDR_CHANNEL_SEL = 8'hBB;
  localparam logic [7:0] PAGE_ZERO = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_DONE_BIT = 5;
  localparam int CTL_BUSY_BIT = 4;
  localparam int CTL_WINDOW_BIT = 1;
  localparam int CTL_LEFT_BIT = 0;
  localparam int CFG_DIV_LSB = 3;
  localparam int CFG_DIV_WIDTH = 5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_CONFIG = 8'hF8;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_LIMIT = 8'h00;
  localparam logic [7:0] RST_RESULT = 8'h00;
  localparam logic [7:0] RST_PAIR = 8'h00;
  localparam logic [7:0] RST_CHANNEL = 8'h00;
  localparam logic [3:0] PAIR_MASK = 4'hF;

  // ****************************************
  // Timing
  // ****************************************
  localparam int SYS_CLK_MHZ = 100;
  localparam int SAR_CLK_MAX_KHZ = 2500;
  localparam int CONV_SAR_CLOCKS = 16;
  localparam logic [4:0] CONV_SAR_COUNT = 5'(CONV_SAR_CLOCKS);
  localparam int RESULT_BITS = 12;
endpackage

// ===== arfw_sar_timer.sv
// SAR clock divider and conversion length counter
`timescale 1ns/100ps
`default_nettype none
module arfw_sar_timer (
  input wire logic refClk,
  input wire logic rstN,
  input wire logic [4:0] divider,
  input wire logic start,
  output logic busy,
  output logic done
);
  logic [4:0] divCnt_r;
  logic [4:0] sarCnt_r;
  logic busy_r;
  logic sarTick;
  logic lastTick;

  // One SAR period is divider+1 system clocks
  assign sarTick = busy_r && (divCnt_r == divider);
  assign lastTick = sarTick && (sarCnt_r == arfw_pkg::CONV_SAR_COUNT - 5'h01);
  assign busy = busy_r;

  always_ff @(posedge refClk or negedge rstN) begin
    if (!rstN) begin
      divCnt_r <= 5'h00;
      sarCnt_r <= 5'h00;
      busy_r <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= lastTick;
      if (start && !busy_r) begin
        busy_r <= 1'b1;
        divCnt_r <= 5'h00;
        sarCnt_r <= 5'h00;
      end else if (busy_r) begin
        divCnt_r <= sarTick ? 5'h00 : divCnt_r + 5'h01;
        if (sarTick) sarCnt_r <= sarCnt_r + 5'h01;
        if (lastTick) busy_r <= 1'b0;
      end
    end
  end

  // Helper: SAR periods elapsed in the current conversion
  logic [4:0] spent_r;
  always_ff @(posedge refClk or negedge rstN) begin
    if (!rstN) spent_r <= 5'h00;
    else if (start && !busy_r) spent_r <= 5'h00;
    else if (sarTick) spent_r <= spent_r + 5'h01;
  end

  a_conv_length: assert property (@(posedge refClk) disable iff (!rstN)
    done |-> spent_r == arfw_pkg::CONV_SAR_COUNT)
    else $error("conversion ended before sixteen SAR clocks");
  a_done_clears_busy: assert property (@(posedge refClk) disable iff (!rstN)
    lastTick |=> !busy_r && done)
    else $error("busy did not fall with done");
endmodule // arfw_sar_timer
`default_nettype wire

// ===== arfw_formatter.sv
// Packs a 12-bit result into high and low bytes and applies the window compare
`timescale 1ns/100ps
`default_nettype none
module arfw_formatter (
  input wire logic [11:0] code,
  input wire logic leftAlign,
  input wire logic differential,
  input wire logic [15:0] gtLimit,
  input wire logic [15:0] ltLimit,
  output logic [7:0] highByte,
  output logic [7:0] lowByte,
  output logic hit
);
  logic [3:0] extend;
  logic [15:0] word;
  logic signed [16:0] wordS;
  logic signed [16:0] gtS;
  logic signed [16:0] ltS;
  logic below;
  logic above;

  // Sign fill only for differential pairs; single-ended stays unsigned
  assign extend = differential ? {4{code[11]}} : 4'h0;
  assign highByte = leftAlign ? code[11:4] : {extend, code[11:8]};
  assign lowByte = leftAlign ? {code[3:0], 4'h0} : code[7:0];
  assign word = {highByte, lowByte};

  // Compare in the current format: signed for differential, unsigned otherwise
  assign wordS = differential ? {word[15], word} : {1'b0, word};
  assign gtS = differential ? {gtLimit[15], gtLimit} : {1'b0, gtLimit};
  assign ltS = differential ? {ltLimit[15], ltLimit} : {1'b0, ltLimit};
  assign below = wordS < ltS;
  assign above = wordS > gtS;
  // Limits crossed select inside window, otherwise outside
  assign hit = (ltS > gtS) ? (below && above) : (below || above);
endmodule // arfw_formatter
`default_nettype wire

// ===== arfw_core_model.sv
// Behavioural converter core that supplies conversion codes to the back end
`timescale 1ns/100ps
`default_nettype none
module arfw_core_model (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic convStart,
  input wire logic convActive,
  input wire logic [11:0] nextCode,
  output logic [11:0] coreCode
);
  logic [11:0] held_r;
  logic [1:0] tail_r;
  logic codeValid;
  assign codeValid = convActive || (tail_r != 2'h0);
  // Outside the sampling window the code is inverted so a late sample shows up
  assign coreCode = codeValid ? held_r : ~held_r;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      held_r <= 12'h000;
      tail_r <= 2'h0;
    end else begin
      if (convStart) begin
        held_r <= nextCode;
      end
      if (convActive) begin
        tail_r <= 2'h2;
      end else if (tail_r != 2'h0) begin
        tail_r <= tail_r - 2'h1;
      end
    end
  end
endmodule // arfw_core_model
`default_nettype wire

// ===== arfw_testbench.sv
// Self-checking testbench for the converter result formatter and window detector
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic ref_clk, arst_n, sfrWrite, sfrRead;
  logic [7:0] sfrAddr, sfrPage, sfrWdata, sfrRdata;
  logic [11:0] coreCode, nextCode;
  logic convStart, convActive, convDoneIrq, windowIrq;
  logic [15:0] gtLim, ltLim;
  logic flagExp;
  logic [3:0] chanNow;
  logic [7:0] expQ[$];
  int bad_count, tests_run, cycles, starts;
  localparam logic [11:0] CODES [11] = '{12'hFFF, 12'h800, 12'h7FF, 12'h000, 12'h7FF,
    12'h400, 12'h001, 12'h000, 12'hFFF, 12'hC00, 12'h800};

  arfw_result_window i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .sfrAddr(sfrAddr),
    .sfrPage(sfrPage), .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata),
    .sfrRdata(sfrRdata), .coreCode(coreCode), .convStart(convStart),
    .convActive(convActive), .convDoneIrq(convDoneIrq), .windowIrq(windowIrq));
  arfw_core_model i_core (.ref_clk(ref_clk), .arst_n(arst_n), .convStart(convStart),
    .convActive(convActive), .nextCode(nextCode), .coreCode(coreCode));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ****************************************
  // Reporting
  // ****************************************
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk16(input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk1(input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // Read data is settled while the qualifier is held, so compare at the edge
  always @(posedge ref_clk) begin
    if (sfrRead === 1'b1) begin
      if (expQ.size() == 0) begin
        chk16(16'hFFFF, {8'h00, sfrRdata});
      end else begin
        chk16({8'h00, expQ.pop_front()}, {8'h00, sfrRdata});
      end
    end
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (convStart === 1'b1) starts++;
    if (cycles == 40000) begin
      bad_count++;
      end_sim();
    end
  end

  // ****************************************
  // Register access and models
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] pg = 8'h00);
    @(negedge ref_clk);
    sfrAddr = a;
    sfrPage = pg;
    sfrWdata = d;
    sfrWrite = 1'b1;
    @(negedge ref_clk);
    sfrWrite = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] pg = 8'h00);
    @(negedge ref_clk);
    sfrAddr = a;
    sfrPage = pg;
    sfrRead = 1'b1;
    expQ.push_back(e);
    @(negedge ref_clk);
    sfrRead = 1'b0;
  endtask

  function automatic logic [15:0] fmt(input logic [11:0] c, input logic lj, input logic d);
    return lj ? {c, 4'h0} : {(d ? {4{c[11]}} : 4'h0), c};
  endfunction

  function automatic logic hitExp(input logic [15:0] w, input logic d);
    logic signed [16:0] v, g, l;
    v = d ? {w[15], w} : {1'b0, w};
    g = d ? {gtLim[15], gtLim} : {1'b0, gtLim};
    l = d ? {ltLim[15], ltLim} : {1'b0, ltLim};
    return (l > g) ? (v > g && v < l) : (v < l || v > g);
  endfunction

  task automatic setLim(input logic [15:0] g, input logic [15:0] l);
    gtLim = g;
    ltLim = l;
    wr(arfw_pkg::ADDR_GT_LOW, g[7:0]);
    wr(arfw_pkg::ADDR_GT_HIGH, g[15:8]);
    wr(arfw_pkg::ADDR_LT_LOW, l[7:0]);
    wr(arfw_pkg::ADDR_LT_HIGH, l[15:8]);
  endtask

  // Divider stays at its slowest setting; even that exceeds the SAR clock ceiling here
  task automatic convert(input logic [11:0] c, input logic lj, input logic d, input logic keep);
    logic [15:0] w;
    int n;
    w = fmt(c, lj, d);
    nextCode = c;
    wr(arfw_pkg::ADDR_PAIR_CONFIG, !d ? 8'h00 : (chanNow[3:1] == 3'h2) ? 8'h08 :
      (chanNow[3:1] == 3'h1) ? 8'h02 : 8'h01);
    wr(arfw_pkg::ADDR_CHANNEL_SEL, {4'h0, chanNow});
    if (!keep) begin
      flagExp = 1'b0;
    end
    wr(arfw_pkg::ADDR_CONTROL, {6'h20, flagExp, lj});
    repeat (150) @(negedge ref_clk);
    wr(arfw_pkg::ADDR_CONTROL, {6'h24, flagExp, lj});
    n = 0;
    while (convActive !== 1'b1 && n < 5) begin
      @(negedge ref_clk);
      n++;
    end
    n = 0;
    while (convActive === 1'b1 && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
    chk16(16'(16 * 32), 16'(n));
    flagExp = flagExp | hitExp(w, d);
    repeat (3) @(negedge ref_clk);
    chk1(flagExp, windowIrq);
    chk1(1'b1, convDoneIrq);
    rd(arfw_pkg::ADDR_CONTROL, {6'h28, flagExp, lj});
    rd(arfw_pkg::ADDR_RESULT_LOW, w[7:0]);
    rd(arfw_pkg::ADDR_RESULT_HIGH, w[15:8]);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] r;
    logic lj, d;
    sfrAddr = 8'h00;
    sfrPage = 8'h00;
    sfrWdata = 8'h00;
    sfrWrite = 1'b0;
    sfrRead = 1'b0;
    nextCode = 12'h000;
    flagExp = 1'b0;
    chanNow = 4'h0;
    gtLim = 16'h0000;
    ltLim = 16'h0000;
    arst_n = 1'b0;
    void'($urandom(38452));
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(arfw_pkg::ADDR_LT_HIGH, arfw_pkg::RST_LIMIT);
    rd(arfw_pkg::ADDR_CONFIG, arfw_pkg::RST_CONFIG);
    rd(arfw_pkg::ADDR_CONTROL, arfw_pkg::RST_CONTROL);
    rd(8'hC0, 8'h00);
    rd(arfw_pkg::ADDR_RESULT_LOW, 8'h00, 8'h01);
    for (int i = 0; i < 4; i++) begin
      r = 8'($urandom);
      wr(arfw_pkg::ADDR_GT_LOW + 8'(i), r);
      wr(arfw_pkg::ADDR_GT_LOW + 8'(i), ~r, 8'h01);
      rd(arfw_pkg::ADDR_GT_LOW + 8'(i), r);
    end
    setLim(16'h0000, 16'h0000);
    for (int i = 0; i < 11; i++) begin
      convert(CODES[i], 1'b0, i >= 4, 1'b0);
      wr(arfw_pkg::ADDR_CONTROL, 8'h81);
      rd(arfw_pkg::ADDR_RESULT_LOW, 8'(fmt(CODES[i], 1'b1, i >= 4)));
      rd(arfw_pkg::ADDR_RESULT_HIGH, 8'(fmt(CODES[i], 1'b1, i >= 4) >> 8));
    end
    setLim(16'h0100, 16'h0F00);
    convert(12'h200, 1'b0, 1'b0, 1'b0);
    convert(12'h000, 1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      lj = 1'($urandom);
      chanNow = 4'($urandom % 6);
      d = 1'($urandom);
      setLim(16'($urandom), 16'($urandom));
      convert(12'($urandom), lj, d, 1'b0);
    end
    chk16(16'h0013, 16'(starts));
    end_sim();
  end
endmodule // testbench
`default_nettype wire
